// ---- fnsi_consts.svh ----
/*
  Constants for the fieldbus node state indicator: timing, pattern slots,
  counter widths and reset values.
  Assumes a 100 MHz system clock and inclusion by bare name.
*/
`ifndef FNSI_CONSTS_SVH
`define FNSI_CONSTS_SVH

// pattern time base: one slot is 50 ms, twenty slots make one second
`define FNSI_CLK_KHZ        100000
`define FNSI_SLOT_MS        50
`define FNSI_SLOT_W         5
`define FNSI_SLOT_LAST      5'h13
`define FNSI_FLASH_ON_END   5'h04
`define FNSI_FLASH2_START   5'h08
`define FNSI_FLASH2_END     5'h0C
`define FNSI_DIV_W          32
`define FNSI_DIV_ZERO       32'h0000_0000

// timeout window counter
`define FNSI_TMO_W          32
`define FNSI_TMO_ZERO       32'h0000_0000
`define FNSI_TMO_ONE        32'h0000_0001

`endif

// ---- fnsi_pkg.sv ----
/*
  Types shared by the node state indicator modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fnsi_pkg;

  // node states, binary coded
  typedef enum logic [1:0] {
    FNSI_INACTIVE           = 2'b00,
    FNSI_PLAIN_ETHERNET     = 2'b01,
    FNSI_PREOP_FIRST_STATE  = 2'b10,
    FNSI_PREOP_SECOND_STATE = 2'b11
  } fnsi_state_t;

  // events seen on the network, one-cycle pulses
  typedef struct packed {
    logic frame_seen;   // any protocol frame from another node
    logic soc_seen;     // start-of-cycle frame
  } fnsi_net_t;

  // state reported to the rest of the interface
  typedef struct packed {
    fnsi_state_t node_state;
    logic        eth_mode;        // port runs as plain tcp/ip ethernet
    logic        reduced_cycle;   // managing node in reduced-cycle operation
    logic        accept_config;   // controlled node takes configuration
    logic        managing_active; // managing function started
  } fnsi_status_t;

endpackage : fnsi_pkg

// ---- fnsi_phase.sv ----
/*
  Free-running pattern phase: a clock divider giving one-slot steps and a
  slot counter that wraps once per second.
  Assumes restart is synchronous and one cycle wide.
*/
`include "fnsi_consts.svh"

module fnsi_phase #(
  parameter logic [31:0] TICK_CYCLES = `FNSI_SLOT_MS * `FNSI_CLK_KHZ
) (
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rstn,
  // control
  input  wire logic                    restart,
  // phase
  output logic [`FNSI_SLOT_W-1:0]      slot
);
  import fnsi_pkg::*;

  logic [`FNSI_DIV_W-1:0]  div;
  logic [`FNSI_DIV_W-1:0]  next_div;
  logic [`FNSI_SLOT_W-1:0] next_slot;

  // divider and slot step; restart puts the pattern back at its start
  always_comb begin
    next_div  = div + `FNSI_TMO_ONE;
    next_slot = slot;
    if (restart) begin
      next_div  = `FNSI_DIV_ZERO;
      next_slot = '0;
    end else if (div >= TICK_CYCLES - `FNSI_TMO_ONE) begin
      next_div  = `FNSI_DIV_ZERO;
      next_slot = (slot == `FNSI_SLOT_LAST) ? '0 : slot + 5'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      div  <= `FNSI_DIV_ZERO;
      slot <= '0;
    end else begin
      div  <= next_div;
      slot <= next_slot;
    end
  end

  a_slot_restart: assert property (@(posedge clk_sys) disable iff (!rstn)
    restart |=> (slot == '0 && div == `FNSI_DIV_ZERO))
    else $error("pattern phase did not restart");

endmodule : fnsi_phase

// ---- fnsi_node.sv ----
/*
  Node state sequencer and status led driver for a real-time ethernet
  node interface that acts as managing or controlled node.
  Assumes network event pulses synchronous to clk_sys; rstn is the
  interface reset and is the only way out of some states.
*/
`include "fnsi_consts.svh"

module fnsi_node #(
  parameter logic [31:0] SLOT_CYCLES = `FNSI_SLOT_MS * `FNSI_CLK_KHZ
) (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rstn,
  // configuration, captured after reset
  input  wire logic                  role_managing,
  input  wire logic [`FNSI_TMO_W-1:0] timeout_cycles,
  // network events
  input  fnsi_pkg::fnsi_net_t        net,
  // indicators and status
  output logic                       led_green,
  output logic                       led_red,
  output fnsi_pkg::fnsi_status_t     status
);
  import fnsi_pkg::*;

  fnsi_state_t             state;
  fnsi_state_t             next_state;
  logic                    loaded;
  logic                    next_loaded;
  logic                    managing_role;
  logic                    next_managing_role;
  logic [`FNSI_TMO_W-1:0]  tmo_len;
  logic [`FNSI_TMO_W-1:0]  next_tmo_len;
  logic [`FNSI_TMO_W-1:0]  tmo_cnt;
  logic [`FNSI_TMO_W-1:0]  next_tmo_cnt;
  logic                    tmo_done;
  logic                    controlled_role;
  logic [`FNSI_SLOT_W-1:0] slot;
  logic                    restart;
  logic                    next_led_green;
  logic                    next_led_red;
  fnsi_status_t            next_status;

  assign controlled_role = !managing_role;
  // one counter serves both the startup window and the failure watchdog
  assign tmo_done = (tmo_cnt + `FNSI_TMO_ONE) >= tmo_len;
  assign restart  = (next_state != state);

  // pattern phase, restarted on every change of node state
  fnsi_phase #(
    .TICK_CYCLES (SLOT_CYCLES)
  ) u_phase (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .restart (restart),
    .slot    (slot)
  );

  // state sequencing
  always_comb begin
    next_state         = state;
    next_loaded        = loaded;
    next_managing_role = managing_role;
    next_tmo_len       = tmo_len;
    next_tmo_cnt       = tmo_cnt + `FNSI_TMO_ONE;
    if (!loaded) begin
      // first cycle after reset: take the window length and role
      next_loaded        = 1'b1;
      next_managing_role = role_managing;
      next_tmo_len       = timeout_cycles;
      next_tmo_cnt       = `FNSI_TMO_ZERO;
    end else begin
      case (state)
        FNSI_INACTIVE: begin
          if (net.frame_seen) begin
            // another node already runs the network
            if (managing_role) begin
              next_state = FNSI_PLAIN_ETHERNET;
            end else begin
              next_state = FNSI_PREOP_FIRST_STATE;
            end
          end else if (tmo_done) begin
            if (managing_role) begin
              next_state = FNSI_PREOP_FIRST_STATE;
            end else begin
              next_state = FNSI_PLAIN_ETHERNET;
            end
          end
        end
        FNSI_PLAIN_ETHERNET: begin
          // managing role is stuck here until the interface is reset
          if (controlled_role && net.frame_seen) begin
            next_state = FNSI_PREOP_FIRST_STATE;
          end
        end
        FNSI_PREOP_FIRST_STATE: begin
          if (controlled_role && net.soc_seen) begin
            next_state = FNSI_PREOP_SECOND_STATE;
          end
        end
        FNSI_PREOP_SECOND_STATE: begin
          next_state = state;
        end
        default: begin
          next_state = FNSI_INACTIVE;
        end
      endcase
      // watchdog restarts on traffic or a new state; it saturates at the end
      if (net.frame_seen || next_state != state) begin
        next_tmo_cnt = `FNSI_TMO_ZERO;
      end else if (tmo_done) begin
        next_tmo_cnt = tmo_cnt;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state         <= FNSI_INACTIVE;
      loaded        <= 1'b0;
      managing_role <= 1'b0;
      tmo_len       <= `FNSI_TMO_ZERO;
      tmo_cnt       <= `FNSI_TMO_ZERO;
    end else begin
      state         <= next_state;
      loaded        <= next_loaded;
      managing_role <= next_managing_role;
      tmo_len       <= next_tmo_len;
      tmo_cnt       <= next_tmo_cnt;
    end
  end

  // led patterns and status, all registered so outputs come from flops
  always_comb begin
    next_led_green = 1'b0;
    next_led_red   = 1'b0;
    case (state)
      FNSI_INACTIVE: begin
        next_led_green = 1'b0;
      end
      FNSI_PLAIN_ETHERNET: begin
        next_led_green = slot[0]; // 50 ms on, 50 ms off
      end
      FNSI_PREOP_FIRST_STATE: begin
        next_led_green = (slot < `FNSI_FLASH_ON_END);
        // red means no frame from the managing node for a whole window
        next_led_red   = controlled_role && loaded && tmo_done;
      end
      FNSI_PREOP_SECOND_STATE: begin
        next_led_green = (slot < `FNSI_FLASH_ON_END) ||
                         (slot >= `FNSI_FLASH2_START && slot < `FNSI_FLASH2_END);
      end
      default: begin
        next_led_green = 1'b0;
      end
    endcase
    next_status                 = '0;
    next_status.node_state      = next_state;
    next_status.eth_mode        = (next_state == FNSI_PLAIN_ETHERNET);
    next_status.managing_active = next_loaded && next_managing_role &&
                                  next_state[1];
    // reduced cycle only: cyclic traffic is not started in this state
    next_status.reduced_cycle   = next_managing_role &&
                                  next_state == FNSI_PREOP_FIRST_STATE;
    next_status.accept_config   = next_loaded && !next_managing_role &&
                                  next_state[1];
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      led_green <= 1'b0;
      led_red   <= 1'b0;
      status    <= '0;
    end else begin
      led_green <= next_led_green;
      led_red   <= next_led_red;
      status    <= next_status;
    end
  end

  a_green_off_inactive: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == FNSI_INACTIVE) ##1 (state == FNSI_INACTIVE) |-> !led_green)
    else $error("green led lit while inactive");

  a_mn_quiet_preop: assert property (@(posedge clk_sys) disable iff (!rstn)
    (loaded && managing_role && state == FNSI_INACTIVE && !net.frame_seen && tmo_done)
    |=> (state == FNSI_PREOP_FIRST_STATE) ##1 status.reduced_cycle)
    else $error("managing role missed timeout entry");

  a_mn_traffic_block: assert property (@(posedge clk_sys) disable iff (!rstn)
    (loaded && managing_role && state == FNSI_INACTIVE && net.frame_seen)
    |=> (state == FNSI_PLAIN_ETHERNET) ##1 !status.managing_active)
    else $error("managing function started despite traffic");

  a_cn_quiet_plain: assert property (@(posedge clk_sys) disable iff (!rstn)
    (loaded && !managing_role && state == FNSI_INACTIVE && !net.frame_seen && tmo_done)
    |=> (state == FNSI_PLAIN_ETHERNET))
    else $error("controlled role missed plain ethernet entry");

  a_cn_traffic_preop: assert property (@(posedge clk_sys) disable iff (!rstn)
    (loaded && !managing_role && state == FNSI_INACTIVE && net.frame_seen)
    |=> (state == FNSI_PREOP_FIRST_STATE))
    else $error("controlled role missed first preop entry");

  a_mn_plain_stuck: assert property (@(posedge clk_sys) disable iff (!rstn)
    (managing_role && state == FNSI_PLAIN_ETHERNET) |=> (state == FNSI_PLAIN_ETHERNET))
    else $error("managing role left plain ethernet without reset");

  a_cn_plain_exit: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!managing_role && state == FNSI_PLAIN_ETHERNET && net.frame_seen)
    |=> (state == FNSI_PREOP_FIRST_STATE))
    else $error("controlled role ignored traffic in plain ethernet");

  a_cn_soc_second: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!managing_role && state == FNSI_PREOP_FIRST_STATE && net.soc_seen)
    |=> (state == FNSI_PREOP_SECOND_STATE) ##1 status.accept_config)
    else $error("start-of-cycle frame did not advance state");

  a_red_cn_only: assert property (@(posedge clk_sys) disable iff (!rstn)
    led_red |-> ($past(state) == FNSI_PREOP_FIRST_STATE && !managing_role))
    else $error("red led lit outside controlled first preop");

  a_flicker_toggle: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == FNSI_PLAIN_ETHERNET && $past(state) == FNSI_PLAIN_ETHERNET)
    |=> (led_green == $past(slot[0])))
    else $error("flicker does not follow slot phase");

  a_single_flash: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == FNSI_PREOP_FIRST_STATE && slot == `FNSI_FLASH2_START) |=> !led_green)
    else $error("single flash lit in its second window");

  a_double_flash: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == FNSI_PREOP_SECOND_STATE && slot == `FNSI_FLASH2_START) |=> led_green)
    else $error("double flash missing its second pulse");

endmodule : fnsi_node

// ---- fnsi_peer.sv ----
/*
  Peer model: the other nodes on the network, turning bench commands into
  one-cycle frame and start-of-cycle pulses at the node's network port.
  Assumes commands change just after a rising edge of clk_sys.
*/
module fnsi_peer (
  // clock and reset
  input  wire logic            clk_sys,
  input  wire logic            rstn,
  // commands from the bench
  input  wire logic            send_frame,
  input  wire logic            send_soc,
  // events seen by the node
  output fnsi_pkg::fnsi_net_t  net
);
  timeunit 1ns;
  timeprecision 1ps;
  import fnsi_pkg::*;

  // a start-of-cycle frame is a protocol frame too, so it also shows as traffic
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      net <= '0;
    end else begin
      net.frame_seen <= send_frame | send_soc;
      net.soc_seen   <= send_soc;
    end
  end
endmodule : fnsi_peer

// ---- test_fnsi_node.sv ----
/*
  Self-checking bench for the node state sequencer and its led patterns.
  Assumes the peer model and a short pattern slot of four cycles.
*/
module test_fnsi_node;
  timeunit 1ns;
  timeprecision 1ps;
  import fnsi_pkg::*;

  localparam int SLOT = 4;
  localparam int W    = 20;

  logic         clk_sys, rstn, role_managing, send_frame, send_soc;
  logic [31:0]  timeout_cycles;
  fnsi_net_t    net;
  logic         led_green, led_red;
  fnsi_status_t status;
  int           mismatches = 0;
  int           checks = 0;
  int           n;

  fnsi_peer peer_u (.clk_sys(clk_sys), .rstn(rstn), .send_frame(send_frame),
                    .send_soc(send_soc), .net(net));
  fnsi_node #(.SLOT_CYCLES(SLOT)) dut_u (.clk_sys(clk_sys), .rstn(rstn),
    .role_managing(role_managing), .timeout_cycles(timeout_cycles), .net(net),
    .led_green(led_green), .led_red(led_red), .status(status));

  // 100 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // reset held four cycles; config settles one edge after release
  task automatic restart(input logic role, input int win);
    @(posedge clk_sys);
    rstn <= 1'b0;
    role_managing <= role;
    timeout_cycles <= win;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask : restart

  task automatic pulse(input logic f, input logic s);
    @(posedge clk_sys);
    send_frame <= f;
    send_soc <= s;
    @(posedge clk_sys);
    send_frame <= 1'b0;
    send_soc <= 1'b0;
  endtask : pulse

  // sampled on the falling edge so the state flops have settled
  task automatic wait_state(input fnsi_state_t s, input int lim, output int cnt);
    cnt = 0;
    @(negedge clk_sys);
    while (status.node_state !== s && cnt < lim) begin
      @(negedge clk_sys);
      cnt++;
    end
    check(status.node_state, s);
  endtask : wait_state

  // counts lit cycles over cyc cycles; over one full pattern period any phase gives the same lit count
  task automatic green_over(input int cyc, input int exp);
    int ones;
    ones = 0;
    repeat (cyc) begin
      @(negedge clk_sys);
      if (led_green === 1'b1) ones++;
    end
    check(ones, exp);
  endtask : green_over

  task automatic t_ctl_quiet;
    restart(1'b0, W);
    green_over(W / 2, 0);
    wait_state(FNSI_PLAIN_ETHERNET, W + 4, n);
    check(status.eth_mode, 1'b1);
    green_over(20 * SLOT, 10 * SLOT);
    pulse(1'b1, 1'b0);
    wait_state(FNSI_PREOP_FIRST_STATE, 6, n);
    check(status.accept_config, 1'b1);
    green_over(20 * SLOT, 4 * SLOT);
    check(led_red, 1'b1);
    pulse(1'b0, 1'b1);
    wait_state(FNSI_PREOP_SECOND_STATE, 6, n);
    green_over(20 * SLOT, 8 * SLOT);
    $display("test ctl_quiet done");
  endtask : t_ctl_quiet

  task automatic t_ctl_early;
    restart(1'b0, W);
    pulse(1'b0, 1'b1);
    pulse(1'b1, 1'b0);
    wait_state(FNSI_PREOP_FIRST_STATE, 6, n);
    check(led_red, 1'b0);
    $display("test ctl_early done");
  endtask : t_ctl_early

  // entry lands win edges after the load edge; the first sample sees the
  // status of the second edge after release, so exactly win - 1 waits pass
  task automatic t_mgr_quiet(input int win);
    restart(1'b1, win);
    wait_state(FNSI_PREOP_FIRST_STATE, win + 6, n);
    check(n, win - 1);
    check(status.reduced_cycle, 1'b1);
    check(status.managing_active, 1'b1);
    pulse(1'b0, 1'b1);
    // the node takes the peer's frame one edge after pulse returns; judge after it
    @(posedge clk_sys);
    wait_state(FNSI_PREOP_FIRST_STATE, 0, n);
    $display("test mgr_quiet done");
  endtask : t_mgr_quiet

  task automatic t_mgr_early;
    restart(1'b1, W);
    pulse(1'b1, 1'b0);
    wait_state(FNSI_PLAIN_ETHERNET, 6, n);
    check(status.managing_active, 1'b0);
    repeat (3) pulse(1'b1, 1'b0);
    // whole pattern periods only, so the lit count does not depend on phase
    green_over(20 * SLOT, 10 * SLOT);
    wait_state(FNSI_PLAIN_ETHERNET, 0, n);
    $display("test mgr_early done");
  endtask : t_mgr_early

  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // main sequence
  initial begin
    rstn = 1'b0;
    role_managing = 1'b0;
    timeout_cycles = W;
    send_frame = 1'b0;
    send_soc = 1'b0;
    t_ctl_quiet();
    t_ctl_early();
    t_mgr_quiet(W);
    t_mgr_quiet(2 * W);
    t_mgr_early();
    print_verdict();
  end

  // whole run is well under a thousand cycles; a hang is cut at five thousand
  initial begin
    repeat (5000) @(posedge clk_sys);
    mismatches++;
    print_verdict();
  end
endmodule : test_fnsi_node
